// File: logic/ssr_regs.sv
// Sequencer stack registers with part identity, word port, plain register port and sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_regs #(
    parameter int ENTRIES = 4,
    parameter int PTR_W = 2,
    parameter logic [1:0] PART_ID = 2'h1 // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    // Plain register port
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Register word port
    input wire logic [15:0] frame_word,
    input wire logic frame_valid,
    output logic [15:0] frame_rdata,
    output logic frame_rvalid,
    // Sequencer control
    input wire logic seq_run,
    input wire logic seq_restart,
    input wire logic conv_done,
    output logic seq_running,
    output logic [PTR_W-1:0] active_entry,
    output logic [3:0] half_a_channel_code,
    output logic [3:0] half_b_channel_code,
    output logic access_fault
);
    // ----------------------------------------
    // Reset contents of the stack
    // ----------------------------------------
    localparam logic [15:0] RST_WORDS [0:3] = '{
        `SSR_RST_SEQ0,
        `SSR_RST_SEQ1,
        `SSR_RST_SEQ2,
        `SSR_RST_SEQ3
    };

    // ----------------------------------------
    // Word port decode
    // ----------------------------------------
    wire ssr_pkg::ssr_acc_e frame_acc = ssr_pkg::ssr_acc_e'(frame_word[`SSR_ACC_BIT]);
    wire ssr_pkg::ssr_addr_t frame_addr = frame_word[`SSR_ADDR_HI:`SSR_ADDR_LO];
    wire ssr_pkg::ssr_cont_t frame_cont = frame_word[`SSR_CONT_HI:0];
    wire logic frame_wr = frame_valid && (frame_acc == ssr_pkg::SSR_ACC_WRITE);
    wire logic frame_rd = frame_valid && (frame_acc == ssr_pkg::SSR_ACC_READ);

    // ----------------------------------------
    // Plain port decode
    // ----------------------------------------
    wire ssr_pkg::ssr_cont_t bus_cont = reg_wdata[`SSR_CONT_HI:0];

    // Address hits on the identity register
    wire logic bus_hit_id = (reg_addr == `SSR_OFS_ID);
    wire logic frame_hit_id = (frame_addr == `SSR_OFS_ID);

    // Stack base offset and entry hits
    wire ssr_pkg::ssr_addr_t seq_base = `SSR_OFS_SEQ0;
    wire ssr_pkg::ssr_addr_t bus_rel = ssr_pkg::ssr_addr_t'(reg_addr - seq_base);
    wire ssr_pkg::ssr_addr_t frame_rel = ssr_pkg::ssr_addr_t'(frame_addr - seq_base);
    wire logic bus_hit_seq = (reg_addr >= seq_base) && (bus_rel < 6'(ENTRIES));
    wire logic frame_hit_seq = (frame_addr >= seq_base) && (frame_rel < 6'(ENTRIES));
    wire logic [PTR_W-1:0] bus_idx = bus_rel[PTR_W-1:0];
    wire logic [PTR_W-1:0] frame_idx = frame_rel[PTR_W-1:0];

    // Unmapped access or a write to the read-only identity register
    wire logic bus_fault = (reg_wr || reg_rd) && !(bus_hit_id || bus_hit_seq) ||
                           (reg_wr && bus_hit_id);
    wire logic frame_fault = frame_valid && !(frame_hit_id || frame_hit_seq) ||
                             (frame_wr && frame_hit_id);
    wire logic fault_nxt = bus_fault || frame_fault;

    // ----------------------------------------
    // Stack entry storage
    // ----------------------------------------
    ssr_pkg::ssr_cont_t entry_r [0:ENTRIES-1];

    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi = gi + 1) begin : g_entry
            // Plain port write wins over a word port write in the same cycle
            wire logic bus_we = reg_wr && bus_hit_seq && (bus_idx == PTR_W'(gi));
            wire logic frame_we = frame_wr && frame_hit_seq && (frame_idx == PTR_W'(gi));
            wire ssr_pkg::ssr_cont_t entry_nxt = bus_we ? bus_cont :
                                                 (frame_we ? frame_cont : entry_r[gi]);

            // One entry: return flag, half B code, half A code
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    entry_r[gi] <= RST_WORDS[gi][`SSR_CONT_HI:0];
                end else begin
                    entry_r[gi] <= entry_nxt;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read selection
    // ----------------------------------------
    wire ssr_pkg::ssr_cont_t id_cont = {7'h00, PART_ID};
    wire ssr_pkg::ssr_cont_t bus_sel = bus_hit_id ? id_cont :
                                       (bus_hit_seq ? entry_r[bus_idx] : `SSR_CONT_ZERO);
    wire ssr_pkg::ssr_cont_t frame_sel = frame_hit_id ? id_cont :
                                         (frame_hit_seq ? entry_r[frame_idx] : `SSR_CONT_ZERO);

    // Answer words echo read access and the address, contents in the low bits
    wire ssr_pkg::ssr_word_t bus_word = {1'b0, reg_addr, bus_sel};
    wire ssr_pkg::ssr_word_t frame_ans = {1'b0, frame_addr, frame_sel};

    // Registered answers, one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `SSR_WORD_ZERO;
            frame_rdata <= `SSR_WORD_ZERO;
            frame_rvalid <= 1'b0;
            access_fault <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? bus_word : `SSR_WORD_ZERO;
            frame_rdata <= frame_rd ? frame_ans : `SSR_WORD_ZERO;
            frame_rvalid <= frame_rd;
            access_fault <= fault_nxt;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic [PTR_W-1:0] ptr;
    wire ssr_pkg::ssr_cont_t cur_entry = entry_r[ptr];
    wire logic cur_return = cur_entry[`SSR_RET_BIT];

    ssr_seq_step #(
        .ENTRIES(ENTRIES),
        .PTR_W(PTR_W)
    ) u_step (
        .clk(clk),
        .rst_n(rst_n),
        .seq_run(seq_run),
        .seq_restart(seq_restart),
        .conv_done(conv_done),
        .return_flag(cur_return),
        .entry_ptr(ptr),
        .running(seq_running)
    );

    // Channel codes of the active entry, index of the input within each half
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_entry <= '0;
            half_a_channel_code <= 4'h0;
            half_b_channel_code <= 4'h0;
        end else begin
            active_entry <= ptr;
            half_a_channel_code <= cur_entry[`SSR_A_HI:`SSR_A_LO];
            half_b_channel_code <= cur_entry[`SSR_B_HI:`SSR_B_LO];
        end
    end
    // Codes pass through untouched for the channel mux outside
endmodule // ssr_regs
`default_nettype wire

// File: inc/ssr_defs.svh
// Offsets, field positions and reset values of the sequencer stack register slice
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

// ----------------------------------------
// Register word layout
// ----------------------------------------
`define SSR_ACC_BIT 15
`define SSR_ADDR_HI 14
`define SSR_ADDR_LO 9
`define SSR_CONT_HI 8
`define SSR_RET_BIT 8
`define SSR_B_HI 7
`define SSR_B_LO 4
`define SSR_A_HI 3
`define SSR_A_LO 0
`define SSR_ID_HI 1
`define SSR_ID_LO 0

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSR_OFS_ID 6'h10
`define SSR_OFS_SEQ0 6'h20
`define SSR_OFS_SEQ1 6'h21
`define SSR_OFS_SEQ2 6'h22
`define SSR_OFS_SEQ3 6'h23

// ----------------------------------------
// Reset words of the stack entries
// ----------------------------------------
`define SSR_RST_SEQ0 16'h4000
`define SSR_RST_SEQ1 16'h4211
`define SSR_RST_SEQ2 16'h4422
`define SSR_RST_SEQ3 16'h4633

// ----------------------------------------
// Miscellaneous values
// ----------------------------------------
`define SSR_CONT_ZERO 9'h000
`define SSR_WORD_ZERO 16'h0000

`endif

// File: inc/ssr_pkg.sv
// Types shared by the sequencer stack register slice
`default_nettype none
package ssr_pkg;
    // Access kind carried in the top bit of a register word
    typedef enum logic {
        SSR_ACC_READ,
        SSR_ACC_WRITE
    } ssr_acc_e;

    // Sequencer stepping states
    typedef enum logic {
        SSR_SEQ_IDLE,
        SSR_SEQ_RUN
    } ssr_seq_e;

    typedef logic [5:0] ssr_addr_t;
    typedef logic [8:0] ssr_cont_t;
    typedef logic [15:0] ssr_word_t;
endpackage
`default_nettype wire

// File: logic/ssr_seq_step.sv
// Stack pointer stepping of the channel sequencer
`timescale 1ns/1ps
`default_nettype none
module ssr_seq_step #(
    parameter int ENTRIES = 4,
    parameter int PTR_W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic seq_run,
    input wire logic seq_restart,
    input wire logic conv_done,
    input wire logic return_flag,
    output logic [PTR_W-1:0] entry_ptr,
    output logic running
);
    ssr_pkg::ssr_seq_e state_r, state_nxt;
    logic [PTR_W-1:0] ptr_r, ptr_nxt;

    // Last entry of this slice wraps to entry 0
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(ENTRIES - 1);
    localparam logic [PTR_W-1:0] FIRST_PTR = '0;

    wire logic at_last = (ptr_r == LAST_PTR);
    wire logic [PTR_W-1:0] ptr_inc = PTR_W'(ptr_r + 1'b1);
    wire logic [PTR_W-1:0] ptr_step = return_flag ? FIRST_PTR :
                                      (at_last ? FIRST_PTR : ptr_inc);

    // Next state and pointer
    always_comb begin
        state_nxt = state_r;
        ptr_nxt = ptr_r;
        case (state_r)
            ssr_pkg::SSR_SEQ_IDLE: begin
                ptr_nxt = FIRST_PTR;
                if (seq_run) begin
                    state_nxt = ssr_pkg::SSR_SEQ_RUN;
                end
            end
            ssr_pkg::SSR_SEQ_RUN: begin
                if (!seq_run) begin
                    state_nxt = ssr_pkg::SSR_SEQ_IDLE;
                    ptr_nxt = FIRST_PTR;
                end else if (seq_restart) begin
                    ptr_nxt = FIRST_PTR;
                end else if (conv_done) begin
                    ptr_nxt = ptr_step;
                end
            end
            default: begin
                state_nxt = ssr_pkg::SSR_SEQ_IDLE;
                ptr_nxt = FIRST_PTR;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ssr_pkg::SSR_SEQ_IDLE;
            ptr_r <= '0;
        end else begin
            state_r <= state_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    assign entry_ptr = ptr_r;
    assign running = (state_r == ssr_pkg::SSR_SEQ_RUN);
endmodule // ssr_seq_step
`default_nettype wire

// File: sim/ssr_regs_props.sv
// Assertion checker for the sequencer stack register slice
`timescale 1ns/1ps
`default_nettype none
module ssr_regs_props #(
    parameter int ENTRIES = 4, parameter int PTR_W = 2, parameter logic [1:0] PART_ID = 2'h1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] frame_word,
    input wire logic frame_valid,
    input wire logic [15:0] frame_rdata,
    input wire logic frame_rvalid,
    input wire logic seq_run,
    input wire logic seq_restart,
    input wire logic conv_done,
    input wire logic seq_running,
    input wire logic [PTR_W-1:0] active_entry,
    input wire logic [3:0] half_a_channel_code,
    input wire logic [3:0] half_b_channel_code,
    input wire logic access_fault
);
    logic mapped;
    // Identity word and four stack entries decode
    assign mapped = (reg_addr == 6'h10) || (reg_addr[5:2] == 4'h8);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Running with no step request
    sequence s_quiet;
        seq_run && seq_running && !conv_done && !seq_restart;
    endsequence
    sequence s_id_read;
        reg_rd && reg_addr == 6'h10;
    endsequence
    a_rd_echo: assert property (reg_rd |=> reg_rdata[15:9] == {1'b0, $past(reg_addr)})
        else $error("Read word lacks address echo");
    a_rd_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("Read data outside answer cycle");
    a_id_value: assert property (s_id_read |=> reg_rdata[8:0] == {7'h00, PART_ID})
        else $error("Identity word wrong");
    a_id_fault: assert property (reg_wr && reg_addr == 6'h10 |=> access_fault)
        else $error("Identity write not refused");
    a_unmapped_fault: assert property ((reg_rd || reg_wr) && !mapped |=> access_fault)
        else $error("Unmapped access not flagged");
    a_frame_read: assert property (frame_valid && !frame_word[15] |=> frame_rvalid)
        else $error("Read word got no answer");
    a_entry_hold: assert property (s_quiet [*3] |-> $stable(active_entry))
        else $error("Entry moved without a step");
    a_restart_zero: assert property (seq_running && seq_restart |-> ##2 active_entry == '0)
        else $error("Restart missed first entry");
endmodule // ssr_regs_props
bind ssr_regs ssr_regs_props #(.ENTRIES(ENTRIES), .PTR_W(PTR_W), .PART_ID(PART_ID)) ssr_regs_props_inst (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_word, .frame_valid,
    .frame_rdata, .frame_rvalid, .seq_run, .seq_restart, .conv_done, .seq_running, .active_entry,
    .half_a_channel_code, .half_b_channel_code, .access_fault);
`default_nettype wire

// File: sim/ssr_host_model.sv
// Host model that sends register words
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model (
    input wire logic clk,
    output logic [15:0] frame_word,
    output logic frame_valid
);
    initial begin
        frame_word = 16'h0000;
        frame_valid = 1'b0;
    end
    // One word per send; released bus shows inverted data
    task automatic send(input logic [15:0] w);
        @(posedge clk);
        frame_word <= w;
        frame_valid <= 1'b1;
        @(posedge clk);
        frame_word <= ~w;
        frame_valid <= 1'b0;
    endtask
endmodule // ssr_host_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the sequencer stack register slice
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [1:0] ID = 2'h3; // Arbitrary part code
    logic clk, rst_n, reg_wr, reg_rd, frame_valid, frame_rvalid, seq_run, seq_restart, conv_done;
    logic seq_running, access_fault;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, frame_word, frame_rdata;
    logic [1:0] active_entry;
    logic [3:0] half_a_channel_code, half_b_channel_code;
    int failures = 0;
    int checks = 0;
    ssr_regs #(.PART_ID(ID)) ssr_regs_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .frame_word, .frame_valid, .frame_rdata, .frame_rvalid, .seq_run, .seq_restart, .conv_done,
        .seq_running, .active_entry, .half_a_channel_code, .half_b_channel_code, .access_fault);
    ssr_host_model host (.clk, .frame_word, .frame_valid);
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask
    // Step or restart, then look at entry and codes
    task automatic step(input logic r, input logic [1:0] e, input logic [7:0] c);
        @(posedge clk);
        conv_done <= !r;
        seq_restart <= r;
        @(posedge clk);
        conv_done <= 1'b0;
        seq_restart <= 1'b0;
        @(posedge clk);
        #1 chk("active_entry", {14'h0, e}, {14'h0, active_entry});
        chk("codes", {8'h00, c}, {8'h00, half_b_channel_code, half_a_channel_code});
    endtask
    task automatic t_resets();
        rd(6'h10, {7'h10, 7'h00, ID});
        rd(6'h20, 16'h4000);
        rd(6'h21, 16'h4211);
        rd(6'h22, 16'h4422);
        rd(6'h23, 16'h4633);
    endtask
    task automatic t_access();
        wr(6'h21, 16'hfd55);
        rd(6'h21, 16'h4355);
        wr(6'h10, 16'hffff);
        #1 chk("access_fault", 16'h1, {15'h0, access_fault});
        rd(6'h10, {7'h10, 7'h00, ID});
        rd(6'h3f, 16'h7e00);
        chk("access_fault", 16'h1, {15'h0, access_fault});
    endtask
    task automatic t_frame();
        host.send(16'hc4a7);
        #1 chk("frame_rvalid", 16'h0, {15'h0, frame_rvalid});
        host.send(16'h4400);
        #1 chk("frame_rdata", 16'h44a7, frame_rdata);
        chk("frame_rvalid", 16'h1, {15'h0, frame_rvalid});
    endtask
    task automatic t_seq();
        wr(6'h20, 16'h0021);
        @(posedge clk);
        seq_run <= 1'b1;
        step(1'b1, 2'h0, 8'h21);
        step(1'b0, 2'h1, 8'h55);
        step(1'b0, 2'h0, 8'h21);
        wr(6'h21, 16'h0011);
        step(1'b0, 2'h1, 8'h11);
        step(1'b0, 2'h2, 8'ha7);
        step(1'b0, 2'h3, 8'h33);
        step(1'b0, 2'h0, 8'h21);
        chk("seq_running", 16'h1, {15'h0, seq_running});
    endtask
    // Reset in mid-run: written entries fall back to their reset words
    task automatic t_mid_reset();
        @(posedge clk);
        seq_run <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk("codes", 16'h0000, {8'h00, half_b_channel_code, half_a_channel_code});
        t_resets();
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, seq_run, seq_restart, conv_done} = 6'h00;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_resets();
        t_access();
        t_frame();
        t_seq();
        t_mid_reset();
        final_report();
    end
    // Watchdog well beyond the roughly 70 cycles needed
    initial begin
        #100000;
        failures++;
        final_report();
    end
endmodule // tb
`default_nettype wire
